// ===== inc/wdt_params.svh
// Constants of the watchdog block: bus offsets, field positions, reset values and timing.
// Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus with 12-bit addresses.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_CLK_MHZ          100
`define WDT_STARTUP_US       150
`define WDT_STARTUP_CYC      (`WDT_STARTUP_US * `WDT_CLK_MHZ)
`define WDT_CYC_PER_MS       (1000 * `WDT_CLK_MHZ)
`define WDT_PRESET_LONG_MS   1600
`define WDT_PRESET_SHORT_MS  200
`define WDT_CAP_SLOPE_X10    774
`define WDT_CAP_OFFSET_MS    55
`define WDT_PF_X10_PER_NF    10000

`define WDT_OFF_CTRL         12'h000
`define WDT_OFF_CAP          12'h004
`define WDT_OFF_STATUS       12'h008
`define WDT_OFF_IRQ_STS      12'h00C
`define WDT_OFF_IRQ_CLR      12'h010
`define WDT_OFF_IRQ_EN       12'h014

`define WDT_CTRL_USE_CAP     0
`define WDT_ST_ENABLED       0
`define WDT_ST_MODE_LO       1
`define WDT_ST_FAULT_PIN     3
`define WDT_ST_EN_PIN        4
`define WDT_ST_SEL_PIN       5
`define WDT_ST_CAP_PIN       6
`define WDT_IRQ_FAULT        0
`define WDT_IRQ_KICK         1
`define WDT_IRQ_START        2

`define WDT_CAP_RST          32'h0000_0A8C
`define WDT_IRQ_EN_RST       3'h0
`define WDT_RESP_OKAY        2'h0
`define WDT_RESP_SLVERR      2'h2

`endif

// ===== inc/wdt_pkg.sv
// Types shared by the watchdog block: bus carriers, watchdog modes and the core state.
// Assumes wdt_params.svh is on the include path.
`include "wdt_params.svh"

package wdt_pkg;

    typedef enum logic [1:0] {
        WDT_OFF   = 2'h0,
        WDT_START = 2'h1,
        WDT_RUN   = 2'h3,
        WDT_FAULT = 2'h2
    } wdt_mode_type;

    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } wdt_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } wdt_axi_rsp_type;

    typedef struct packed {
        wdt_axi_rsp_type axi;
        logic            aw_hold;
        logic [11:0]     aw_addr;
        logic            w_hold;
        logic [31:0]     w_data;
        logic [3:0]      w_strb;
        logic            use_cap;
        logic [31:0]     cap_pf;
        logic [2:0]      irq_sts;
        logic [2:0]      irq_en;
        logic            irq;
        wdt_mode_type    mode;
        logic [47:0]     cnt;
        logic [47:0]     tmo;
        logic            kick_prev;
        logic            ena_out;
        logic            fault_oe;
    } wdt_state_type;

endpackage

// ===== hw/wdt_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the pins are quasi-static levels; only the second stage is read outside.
`timescale 1ns/10ps
`default_nettype none

module wdt_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_sync
);
    // Stage 0 feeds only stage 1.
    logic [1:0][WIDTH-1:0] st_q;
    logic [1:0][WIDTH-1:0] st_d;

    always_comb begin
        st_d    = st_q;
        st_d[0] = pin_in;
        st_d[1] = st_q[0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_sync = st_q[1];

endmodule

`default_nettype wire

// ===== hw/wdt_core.sv
// Watchdog timer with enable and select disables, open-drain fault pin and AXI4-Lite registers.
// Assumes pins are asynchronous to aclk and that software configures the timeout source.
//
// Operation
// RQ1: Disabled watchdog ignores kicks, releases fault pin.
// RQ2: Re-enable waits 150 us before timing.
// RQ3: Watchdog runs only while select is high.
// RQ4: Select disable leaves enable status untouched.
// RQ5: Enable status output mirrors enable input.
// RQ6: Enable low: status low, fault released.
// RQ7: Controller kicks before minimum timeout elapses.
// RQ8: Missing kick after enable asserts fault low.
// RQ9: Capacitor timeout is 77.4 ms/nF plus 55.
// RQ10: Presets 1600 ms floating, 200 ms pulled.
// RQ11: Kick interval beyond timeout asserts fault.
// RQ12: Each enabled falling kick restarts count. Kicks during the start-up delay are ignored and do not restart its count.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

module wdt_core #(
    parameter logic [47:0] STARTUP_CYC  = 48'(`WDT_STARTUP_CYC),
    parameter logic [47:0] CYC_PER_MS   = 48'(`WDT_CYC_PER_MS),
    parameter logic [47:0] PRESET_LONG  = 48'(`WDT_PRESET_LONG_MS * `WDT_CYC_PER_MS),
    parameter logic [47:0] PRESET_SHORT = 48'(`WDT_PRESET_SHORT_MS * `WDT_CYC_PER_MS)
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire wdt_pkg::wdt_axi_req_type axi_req,
    output var  wdt_pkg::wdt_axi_rsp_type axi_rsp,
    input  wire logic                     kick_input,
    input  wire logic                     timeout_select,
    input  wire logic                     enable_in,
    input  wire logic                     timing_cap_pin,
    input  wire logic                     fault_output_n_i,
    output var  logic                     fault_output_n_o,
    output var  logic                     fault_output_n_oe,
    output var  logic                     enable_status_out,
    output var  logic                     irq
);
    import wdt_pkg::*;

    wdt_state_type s_q;
    wdt_state_type s_d;

    // Synced pin levels; logic never reads a raw pin.
    logic [4:0]  pin_s;
    logic        kick_s;
    logic        sel_s;
    logic        en_s;
    logic        cap_pin_s;
    logic        flt_s;
    logic        ena;
    logic        kick_fall;
    logic        wr_go;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] wmask;
    logic [31:0] rd_data;
    logic [2:0]  ev;
    logic [2:0]  clr;
    logic [47:0] cap_ms;
    logic [47:0] cap_cyc;
    logic [47:0] tmo_sel;

    wdt_sync #(
        .WIDTH(5)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  ({fault_output_n_i, timing_cap_pin, enable_in,
                   timeout_select, kick_input}),
        .pin_sync(pin_s)
    );

    assign kick_s    = pin_s[0];
    assign sel_s     = pin_s[1];
    assign en_s      = pin_s[2];
    assign cap_pin_s = pin_s[3];
    assign flt_s     = pin_s[4];

    // Both the enable pin and the select pin must be high to run.
    // Each pin reaches the sequencer two edges after it moves, which is
    // negligible against the start-up delay.
    assign ena       = en_s & sel_s; // [RQ3]
    // The previous level resets low while the pin idles high, so reset
    // never looks like a kick.
    assign kick_fall = s_q.kick_prev & ~kick_s;

    // The divider is deep but the capacitance changes only by software,
    // and the result is registered before the counter compares against it.
    always_comb begin
        cap_ms  = ((48'(s_q.cap_pf) * 48'(`WDT_CAP_SLOPE_X10))
                  / 48'(`WDT_PF_X10_PER_NF)) + 48'(`WDT_CAP_OFFSET_MS); // [RQ9]
        cap_cyc = 48'(cap_ms * CYC_PER_MS);
        if (s_q.use_cap) begin
            tmo_sel = cap_cyc; // [RQ9]
        end else if (cap_pin_s) begin
            tmo_sel = PRESET_SHORT; // [RQ10]
        end else begin
            tmo_sel = PRESET_LONG; // [RQ10]
        end
    end

    always_comb begin
        wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}},
                 {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
        wr_go = s_q.aw_hold & s_q.w_hold & ~s_q.axi.bvalid;
        unique case (s_q.aw_addr)
            `WDT_OFF_CTRL,
            `WDT_OFF_CAP,
            `WDT_OFF_IRQ_CLR,
            `WDT_OFF_IRQ_EN: wr_hit = 1'b1;
            default:         wr_hit = 1'b0;
        endcase
        clr = '0;
        if (wr_go && s_q.aw_addr == `WDT_OFF_IRQ_CLR) begin
            clr = s_q.w_data[2:0] & wmask[2:0];
        end
    end

    // Register map, one aligned word each:
    // 0x00 control, bit 0 takes the timeout from the capacitance word.
    // 0x04 capacitance in picofarads.
    // 0x08 status, read only: enabled, mode, then the synced pin levels.
    // 0x0C sticky event flags: timeout fault, kick taken, start-up done.
    // 0x10 event clear, write one to clear; it reads as zero.
    // 0x14 event enable, laid out as the flags.
    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        unique case (axi_req.araddr)
            `WDT_OFF_CTRL: begin
                rd_data[`WDT_CTRL_USE_CAP] = s_q.use_cap;
            end
            `WDT_OFF_CAP: begin
                rd_data = s_q.cap_pf;
            end
            `WDT_OFF_STATUS: begin
                rd_data[`WDT_ST_ENABLED]                  = ena;
                rd_data[`WDT_ST_MODE_LO+1:`WDT_ST_MODE_LO] = s_q.mode;
                rd_data[`WDT_ST_FAULT_PIN]                = flt_s;
                rd_data[`WDT_ST_EN_PIN]                   = en_s;
                rd_data[`WDT_ST_SEL_PIN]                  = sel_s;
                rd_data[`WDT_ST_CAP_PIN]                  = cap_pin_s;
            end
            `WDT_OFF_IRQ_STS: begin
                rd_data[2:0] = s_q.irq_sts;
            end
            `WDT_OFF_IRQ_EN: begin
                rd_data[2:0] = s_q.irq_en;
            end
            `WDT_OFF_IRQ_CLR: begin
                rd_data = '0;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        ev  = '0;

        // Write channel: address and data are latched independently.
        // Only one write is under way: both readies stay low until the answer is taken.
        // Read-only and unmapped words change nothing and answer with a slave error.
        if (s_q.axi.bvalid && axi_req.bready) begin
            s_d.axi.bvalid = 1'b0;
        end
        if (s_q.axi.awready && axi_req.awvalid) begin
            s_d.aw_hold = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (s_q.axi.wready && axi_req.wvalid) begin
            s_d.w_hold = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        if (wr_go) begin
            s_d.aw_hold    = 1'b0;
            s_d.w_hold     = 1'b0;
            s_d.axi.bvalid = 1'b1;
            s_d.axi.bresp  = wr_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
            if (s_q.aw_addr == `WDT_OFF_CTRL && s_q.w_strb[0]) begin
                s_d.use_cap = s_q.w_data[`WDT_CTRL_USE_CAP];
            end
            if (s_q.aw_addr == `WDT_OFF_CAP) begin
                s_d.cap_pf = (s_q.cap_pf & ~wmask) | (s_q.w_data & wmask);
            end
            if (s_q.aw_addr == `WDT_OFF_IRQ_EN && s_q.w_strb[0]) begin
                s_d.irq_en = s_q.w_data[2:0];
            end
        end
        s_d.axi.awready = ~s_d.aw_hold & ~s_d.axi.bvalid;
        s_d.axi.wready  = ~s_d.w_hold & ~s_d.axi.bvalid;

        // Read channel: one read outstanding, answered the cycle after.
        // The data word is captured at the address handshake and stands until taken.
        if (s_q.axi.rvalid && axi_req.rready) begin
            s_d.axi.rvalid = 1'b0;
        end
        if (s_q.axi.arready && axi_req.arvalid) begin
            s_d.axi.rvalid = 1'b1;
            s_d.axi.rdata  = rd_data;
            s_d.axi.rresp  = rd_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
        end
        s_d.axi.arready = ~s_d.axi.rvalid;

        // Watchdog sequencer.
        // Off holds the count at zero and ignores the kick pin.
        // Start counts out the start-up delay; kicks are still ignored.
        // Run counts cycles since entry or the last kick and faults at the timeout.
        // Fault pulls the pin until a kick or a disable ends it.
        s_d.kick_prev = kick_s;
        // A new timeout source takes effect one cycle later, as it is registered.
        s_d.tmo       = tmo_sel;
        unique case (s_q.mode)
            WDT_OFF: begin
                // Kicks and missing kicks are ignored here.
                s_d.cnt = '0; // [RQ1]
                if (ena) begin
                    s_d.mode = WDT_START; // [RQ2]
                end
            end
            WDT_START: begin
                if (!ena) begin
                    s_d.mode = WDT_OFF; // [RQ1]
                    s_d.cnt  = '0;
                end else if (s_q.cnt >= STARTUP_CYC - 48'h0000_0000_0001) begin
                    s_d.mode             = WDT_RUN; // [RQ2]
                    s_d.cnt              = '0;
                    ev[`WDT_IRQ_START]   = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 48'h0000_0000_0001;
                end
            end
            WDT_RUN: begin
                if (!ena) begin
                    s_d.mode = WDT_OFF; // [RQ1]
                    s_d.cnt  = '0;
                end else if (kick_fall) begin
                    s_d.cnt           = '0; // [RQ12]
                    ev[`WDT_IRQ_KICK] = 1'b1;
                end else if (s_q.cnt >= s_q.tmo - 48'h0000_0000_0001) begin
                    s_d.mode           = WDT_FAULT; // [RQ8] [RQ11]
                    s_d.cnt            = '0;
                    ev[`WDT_IRQ_FAULT] = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 48'h0000_0000_0001;
                end
            end
            WDT_FAULT: begin
                // A fresh kick ends the fault and restarts supervision.
                if (!ena) begin
                    s_d.mode = WDT_OFF; // [RQ1] [RQ6]
                end else if (kick_fall) begin
                    s_d.mode          = WDT_RUN; // [RQ12]
                    s_d.cnt           = '0;
                    ev[`WDT_IRQ_KICK] = 1'b1;
                end
            end
        endcase

        // The pin is pulled low only in the fault state, else released.
        s_d.fault_oe = (s_d.mode == WDT_FAULT); // [RQ1] [RQ6] [RQ8]
        // Status follows the enable pin alone, never the select pin.
        s_d.ena_out  = en_s; // [RQ4] [RQ5] [RQ6]

        // A new event wins over a clear in the same cycle.
        // The interrupt uses the next flags and enables, so it moves on the same edge
        // as the write that changes them.
        s_d.irq_sts = (s_q.irq_sts & ~clr) | ev;
        s_d.irq     = |(s_d.irq_sts & s_d.irq_en);
    end

    // Synchronous reset; the bus readies come up high so a request can be
    // taken on the first edge after release.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q             <= '0;
            s_q.mode        <= WDT_OFF;
            s_q.cap_pf      <= `WDT_CAP_RST;
            s_q.irq_en      <= `WDT_IRQ_EN_RST;
            s_q.tmo         <= PRESET_LONG;
            s_q.axi.awready <= 1'b1;
            s_q.axi.wready  <= 1'b1;
            s_q.axi.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign axi_rsp           = s_q.axi;
    // The open-drain pin only ever pulls low; the fault state alone decides when.
    assign fault_output_n_o  = 1'b0;
    assign fault_output_n_oe = s_q.fault_oe;
    assign enable_status_out = s_q.ena_out;
    assign irq               = s_q.irq;

endmodule

`default_nettype wire

// ===== tb/wdt_core_assertions.sv
// Checker for the watchdog core: status pin timing, fault timing and bus answer latency.
// Assumes it is bound to wdt_core and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module wdt_core_assertions #(
    parameter logic [47:0] STARTUP_CYC  = 48'h14,
    parameter logic [47:0] CYC_PER_MS   = 48'h0A,
    parameter logic [47:0] PRESET_LONG  = 48'h190,
    parameter logic [47:0] PRESET_SHORT = 48'h64
) (
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire wdt_pkg::wdt_axi_req_type axi_req,
    input wire wdt_pkg::wdt_axi_rsp_type axi_rsp,
    input wire logic                     kick_input,
    input wire logic                     timeout_select,
    input wire logic                     enable_in,
    input wire logic                     timing_cap_pin,
    input wire logic                     fault_output_n_i,
    input wire logic                     fault_output_n_o,
    input wire logic                     fault_output_n_oe,
    input wire logic                     enable_status_out,
    input wire logic                     irq
);
    import wdt_pkg::*;
    // Longest silence the bench allows: start-up plus the 100 pF timeout, with margin.
    localparam int LATE = 700;
    logic        kick_q;
    logic [15:0] idle_q;
    logic [15:0] on_q;
    wire logic   on_w = enable_in & timeout_select;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            kick_q <= 1'b1;
            idle_q <= 16'h0000;
            on_q   <= 16'h0000;
        end else begin
            kick_q <= kick_input;
            on_q   <= on_w ? on_q + 16'(on_q != 16'hFFFF) : 16'h0000;
            idle_q <= (on_w && !(kick_q && !kick_input)) ?
                      idle_q + 16'(idle_q != 16'hFFFF) : 16'h0000;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_drive_low; fault_output_n_o == 1'b0; endproperty
    a_drive_low: assert property (p_drive_low) else $error("fault pin driven high");
    property p_ena_hi; enable_in [*4] |-> enable_status_out; endproperty
    a_ena_hi: assert property (p_ena_hi) else $error("status not high");
    property p_ena_lo; !enable_in [*4] |-> !enable_status_out; endproperty
    a_ena_lo: assert property (p_ena_lo) else $error("status not low");
    property p_off_rel; !(enable_in && timeout_select) [*6] |-> !fault_output_n_oe; endproperty
    a_off_rel: assert property (p_off_rel) else $error("fault while off");
    property p_start; $rose(fault_output_n_oe) |-> on_q >= 16'(STARTUP_CYC + PRESET_SHORT);
    endproperty
    a_start: assert property (p_start) else $error("fault before start-up");
    property p_kick_rst; $rose(fault_output_n_oe) |-> idle_q >= 16'(PRESET_SHORT); endproperty
    a_kick_rst: assert property (p_kick_rst) else $error("fault too soon after kick");
    property p_late; idle_q == 16'(LATE) |-> fault_output_n_oe; endproperty
    a_late: assert property (p_late) else $error("no fault after silence");
    property p_wr_lat;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
            |-> ##2 axi_rsp.bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_rd_lat; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
endmodule
bind wdt_core wdt_core_assertions #(.STARTUP_CYC(STARTUP_CYC), .CYC_PER_MS(CYC_PER_MS),
    .PRESET_LONG(PRESET_LONG), .PRESET_SHORT(PRESET_SHORT)) u_chk (.aclk(aclk),
    .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .kick_input(kick_input),
    .timeout_select(timeout_select), .enable_in(enable_in), .timing_cap_pin(timing_cap_pin),
    .fault_output_n_i(fault_output_n_i), .fault_output_n_o(fault_output_n_o),
    .fault_output_n_oe(fault_output_n_oe), .enable_status_out(enable_status_out), .irq(irq));
`default_nettype wire

// ===== tb/wdt_mcu_model.sv
// Model of the supervised controller: a GPIO giving the kick pin one falling edge per period.
// Assumes the bench sets the period in clock cycles; zero parks the pin high.
`timescale 1ns/10ps
`default_nettype none
module wdt_mcu_model (
    input  wire logic        aclk,
    input  wire logic [15:0] period,
    output wire logic        kick_input
);
    logic [15:0] cnt_q = 16'h0000;
    always_ff @(posedge aclk) begin
        cnt_q <= (period == 16'h0000 || cnt_q >= period - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    end
    // Four cycles low so each pulse survives the device's pin synchroniser.
    assign kick_input = (period == 16'h0000) || (cnt_q >= 16'h0004);
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the watchdog core: register accesses, pin stimulus, fault timing.
// Assumes the shortened counts below and the controller model on the kick pin.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import wdt_pkg::*;
    logic            aclk;
    logic            aresetn;
    wdt_axi_req_type req;
    wdt_axi_rsp_type rsp;
    logic            en;
    logic            sel;
    logic            cap_pin;
    logic            kick;
    logic            fault_o;
    logic            fault_oe;
    logic            status;
    logic            irq;
    logic [15:0]     period;
    wire logic       fault_wire;
    int              n_mismatch;
    int              checked;
    int              cycles;
    // Open-drain line with a pull-up: high unless the device pulls it.
    assign fault_wire = fault_oe ? 1'b0 : 1'b1;
    wdt_core #(.STARTUP_CYC(48'h14), .CYC_PER_MS(48'h0A), .PRESET_LONG(48'h190),
        .PRESET_SHORT(48'h64)) DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
        .axi_rsp(rsp), .kick_input(kick), .timeout_select(sel), .enable_in(en),
        .timing_cap_pin(cap_pin), .fault_output_n_i(fault_wire), .fault_output_n_o(fault_o),
        .fault_output_n_oe(fault_oe), .enable_status_out(status), .irq(irq));
    wdt_mcu_model u_mcu (.aclk(aclk), .period(period), .kick_input(kick));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic close_out();
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        chk("bresp", 32'(er), 32'(rsp.bresp));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        chk("rdata", ed, rsp.rdata);
        chk("rresp", 32'(er), 32'(rsp.rresp));
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Counts cycles until the fault pin is pulled; the window allows for pin synchronisers.
    task automatic fault_in(input int lo, input int hi);
        int n;
        n = 0;
        while (fault_oe !== 1'b1 && n < hi + 10) begin
            @(posedge aclk);
            n++;
        end
        chk("fault_delay", 32'h0000_0001, 32'(n >= lo && n <= hi));
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        aresetn = 1'b0;
        req = '0;
        en = 1'b0;
        sel = 1'b0;
        cap_pin = 1'b0;
        period = 16'h0000;
        n_mismatch = 0;
        checked = 0;
        cycles = 0;
        idle(10);
        aresetn <= 1'b1;
        rd(12'h004, 32'h0000_0A8C, 2'h0);
        rd(12'h014, 32'h0000_0000, 2'h0);
        rd(12'h100, 32'h0000_0000, 2'h2);
        rd(12'h010, 32'h0000_0000, 2'h0);
        wr(12'h008, 32'h0000_0001, 2'h2);
        en <= 1'b1;
        period <= 16'h001E;
        idle(200);
        chk("fault_oe", 32'h0000_0000, 32'(fault_oe));
        chk("enable_status", 32'h0000_0001, 32'(status));
        sel <= 1'b1;
        idle(600);
        rd(12'h00C, 32'h0000_0006, 2'h0);
        period <= 16'h0000;
        sel <= 1'b0;
        wr(12'h010, 32'h0000_0007, 2'h0);
        wr(12'h014, 32'h0000_0001, 2'h0);
        sel <= 1'b1;
        fault_in(418, 430);
        chk("fault_drive", 32'h0000_0000, 32'(fault_o));
        idle(2);
        chk("irq", 32'h0000_0001, 32'(irq));
        rd(12'h008, 32'h0000_0035, 2'h0);
        wr(12'h014, 32'h0000_0000, 2'h0);
        idle(1);
        chk("irq", 32'h0000_0000, 32'(irq));
        period <= 16'h001E;
        idle(100);
        chk("fault_oe", 32'h0000_0000, 32'(fault_oe));
        wr(12'h010, 32'h0000_0001, 2'h0);
        wr(12'h014, 32'h0000_0001, 2'h0);
        idle(1);
        chk("irq", 32'h0000_0000, 32'(irq));
        sel <= 1'b0;
        period <= 16'h0000;
        idle(10);
        chk("fault_oe", 32'h0000_0000, 32'(fault_oe));
        chk("enable_status", 32'h0000_0001, 32'(status));
        rd(12'h008, 32'h0000_0018, 2'h0);
        cap_pin <= 1'b1;
        sel <= 1'b1;
        fault_in(118, 130);
        en <= 1'b0;
        idle(6);
        chk("enable_status", 32'h0000_0000, 32'(status));
        wr(12'h004, 32'h0000_0064, 2'h0);
        wr(12'h000, 32'h0000_0001, 2'h0);
        rd(12'h000, 32'h0000_0001, 2'h0);
        idle(500);
        chk("fault_oe", 32'h0000_0000, 32'(fault_oe));
        en <= 1'b1;
        fault_in(638, 650);
        idle(80);
        close_out();
    end
endmodule
`default_nettype wire
